// >>> core/port_override_defs.vh
`ifndef PORT_OVERRIDE_DEFS_VH
`define PORT_OVERRIDE_DEFS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_PORT_A_PIN_INPUT 4'h0
`define ADDR_PORT_A_DIRECTION 4'h1
`define ADDR_PORT_A_OUTPUT_DATA 4'h2
`define ADDR_PORT_B_PIN_INPUT 4'h3
`define ADDR_PORT_B_DIRECTION 4'h4
`define ADDR_PORT_B_OUTPUT_DATA 4'h5
`define ADDR_PORT_CONTROL 4'h6
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_PULLUP_DISABLE 0
`define CTRL_BBM_A 1
`define CTRL_BBM_B 2
`define CTRL_WIDTH 3
`define RESET_OUTPUT_DATA 8'h00
`define RESET_DIRECTION 8'h00
`define RESET_CONTROL 3'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define BBM_TRISTATE_CYCLES 1
`endif

// >>> core/pin_sync.v
`timescale 1ns/1ns
// Three-stage pin synchroniser; output rises once stages two and three are both one, falls as soon as they differ
module pin_sync #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= (stage2 & stage3) | (sync_out & ~(stage2 ^ stage3));
    end
  end
endmodule

// >>> core/pin_driver.v
`timescale 1ns/1ns
// One port of eight pins: override muxing and break-before-make
module pin_driver #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  input wire bbm_enable,
  input wire pullup_disable,
  input wire [WIDTH-1:0] output_data,
  input wire [WIDTH-1:0] direction,
  input wire [WIDTH-1:0] pullup_override_enable,
  input wire [WIDTH-1:0] pullup_override_value,
  input wire [WIDTH-1:0] direction_override_enable,
  input wire [WIDTH-1:0] direction_override_value,
  input wire [WIDTH-1:0] output_value_override_enable,
  input wire [WIDTH-1:0] output_value_override_value,
  input wire [WIDTH-1:0] input_enable_override_enable,
  input wire [WIDTH-1:0] input_enable_override_value,
  output reg [WIDTH-1:0] pin_out,
  output reg [WIDTH-1:0] pin_oe,
  output reg [WIDTH-1:0] pin_pullup,
  output reg [WIDTH-1:0] pin_input_enable
);
  reg [WIDTH-1:0] prev_dir;
  reg [WIDTH-1:0] eff_dir;
  reg [WIDTH-1:0] eff_val;
  reg [WIDTH-1:0] eff_pu;
  reg [WIDTH-1:0] eff_ie;
  reg [WIDTH-1:0] hold_off;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      always @* begin
        eff_dir[i] = direction_override_enable[i] ? direction_override_value[i] : direction[i];
        eff_val[i] = output_value_override_enable[i] ? output_value_override_value[i] : output_data[i];
        eff_pu[i] = pullup_override_enable[i] ? pullup_override_value[i] :
                    (~eff_dir[i] & output_data[i] & ~pullup_disable);
        eff_ie[i] = input_enable_override_enable[i] ? input_enable_override_value[i] : 1'b1;
        hold_off[i] = bbm_enable & eff_dir[i] & ~prev_dir[i];
      end
    end
  endgenerate
  // Pull-ups forced off in reset whatever the data bits were
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_dir <= {WIDTH{1'b0}};
      pin_out <= {WIDTH{1'b0}};
      pin_oe <= {WIDTH{1'b0}};
      pin_pullup <= {WIDTH{1'b0}};
      pin_input_enable <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      prev_dir <= eff_dir;
      pin_out <= eff_val;
      pin_oe <= eff_dir & ~hold_off;
      pin_pullup <= eff_pu;
      pin_input_enable <= eff_ie;
    end
  end
endmodule

// >>> core/port_pin_override_logic.v
`timescale 1ns/1ns
`include "port_override_defs.vh"
// Overview of operation
// - Pull-ups stay off while reset is held.
// - Timer 1 outputs on port B bits 0..2 reach pins only as outputs.
// - Timer 1 steering bit selects PWM output in place of port data.
// - Three-wire data output replaces port B bit 1 data when output.
// - Port B bit 1 pull-up still works as input with data one.
// - Three-wire data input on port B bit 0 overrides nothing.
// - Port A bits 5,4 direction override on SPI master or two-wire here.
// - Port A bit 5 value: SPI clock if master, else not two-wire-drive.
// - Port A bit 4 direction value: zero if master, else shift-out or data, gated.
// - Port A bit 5 input enable override by ADC disable, start irq, pin change.
// - Port B bit 6 input enable override by ADC disable, int0, pin change.
// - Output data registers read/write, reset zero.
// - Direction registers read/write, one is output, reset zero.
// - Pin input registers read synchronised pin levels.
// - Writing one to pin input bit toggles output data bit.
// - Break-before-make adds one tristate cycle on input-to-output change.
module port_pin_override_logic (
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire [7:0] port_a_pad_in,
  input wire [7:0] port_b_pad_in,
  output reg [7:0] port_a_pad_out,
  output reg [7:0] port_a_pad_oe,
  output reg [7:0] port_a_pullup,
  output reg [7:0] port_a_input_enable,
  output reg [7:0] port_b_pad_out,
  output reg [7:0] port_b_pad_oe,
  output reg [7:0] port_b_pullup,
  output reg [7:0] port_b_input_enable,
  input wire spi_enable_bit,
  input wire spi_master_select,
  input wire spi_clock_out,
  input wire spi_data_out,
  input wire serial_two_wire_active,
  input wire serial_three_wire_active,
  input wire serial_pin_position_select,
  input wire serial_clock_hold,
  input wire serial_shift_out,
  input wire serial_start_irq_enable,
  input wire pin_change_group0_enable,
  input wire pin_change_group1_enable,
  input wire [7:0] pin_change_mask_a,
  input wire [7:0] pin_change_mask_b,
  input wire [7:0] analog_digital_disable_a,
  input wire [7:0] analog_digital_disable_b,
  input wire external_irq0_enabled,
  input wire timer1_out_a,
  input wire timer1_out_b,
  input wire timer1_out_a_enabled,
  input wire timer1_out_b_enabled,
  input wire [7:0] timer1_output_steering_reg
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] port_a_output_data;
  reg [7:0] port_a_direction;
  reg [7:0] port_b_output_data;
  reg [7:0] port_b_direction;
  reg [`CTRL_WIDTH-1:0] port_control;
  wire [7:0] port_a_pin_input;
  wire [7:0] port_b_pin_input;
  wire global_pullup_disable = port_control[`CTRL_PULLUP_DISABLE];
  wire wr_a_pin = reg_write & (reg_addr == `ADDR_PORT_A_PIN_INPUT);
  wire wr_b_pin = reg_write & (reg_addr == `ADDR_PORT_B_PIN_INPUT);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_output_data <= `RESET_OUTPUT_DATA;
      port_a_direction <= `RESET_DIRECTION;
      port_b_output_data <= `RESET_OUTPUT_DATA;
      port_b_direction <= `RESET_DIRECTION;
      port_control <= `RESET_CONTROL;
    end else if (clk_en && reg_write) begin
      case (reg_addr)
        `ADDR_PORT_A_OUTPUT_DATA: port_a_output_data <= reg_wdata;
        `ADDR_PORT_A_DIRECTION: port_a_direction <= reg_wdata;
        `ADDR_PORT_B_OUTPUT_DATA: port_b_output_data <= reg_wdata;
        `ADDR_PORT_B_DIRECTION: port_b_direction <= reg_wdata;
        `ADDR_PORT_CONTROL: port_control <= reg_wdata[`CTRL_WIDTH-1:0];
        default: begin
          // Toggle is independent of direction
          if (wr_a_pin) port_a_output_data <= port_a_output_data ^ reg_wdata;
          if (wr_b_pin) port_b_output_data <= port_b_output_data ^ reg_wdata;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read port: data valid the cycle after the strobe
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_read) begin
        case (reg_addr)
          `ADDR_PORT_A_PIN_INPUT: reg_rdata <= port_a_pin_input;
          `ADDR_PORT_A_DIRECTION: reg_rdata <= port_a_direction;
          `ADDR_PORT_A_OUTPUT_DATA: reg_rdata <= port_a_output_data;
          `ADDR_PORT_B_PIN_INPUT: reg_rdata <= port_b_pin_input;
          `ADDR_PORT_B_DIRECTION: reg_rdata <= port_b_direction;
          `ADDR_PORT_B_OUTPUT_DATA: reg_rdata <= port_b_output_data;
          `ADDR_PORT_CONTROL: reg_rdata <= {5'h00, port_control};
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  pin_sync #(.WIDTH(8)) u_sync_a (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(port_a_pad_in),
    .sync_out(port_a_pin_input)
  );
  pin_sync #(.WIDTH(8)) u_sync_b (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in(port_b_pad_in),
    .sync_out(port_b_pin_input)
  );

  // ----------------------------------------
  // Port A overrides
  // ----------------------------------------
  wire spi_master = spi_enable_bit & spi_master_select;
  wire two_wire_here = serial_two_wire_active & serial_pin_position_select;
  reg [7:0] a_pullup_override_enable, a_pullup_override_value, a_direction_override_enable, a_direction_override_value, a_output_value_override_enable, a_output_value_override_value, a_input_enable_override_enable, a_input_enable_override_value;
  always @* begin
    a_pullup_override_enable = 8'h00;
    a_pullup_override_value = 8'h00;
    a_direction_override_enable = 8'h00;
    a_direction_override_value = 8'h00;
    a_output_value_override_enable = 8'h00;
    a_output_value_override_value = 8'h00;
    // Pin-change and ADC disable on every pin
    a_input_enable_override_enable = analog_digital_disable_a | ({8{pin_change_group0_enable}} & pin_change_mask_a);
    a_input_enable_override_value = {8{pin_change_group0_enable}} & pin_change_mask_a;
    // SPI master owns the pull-ups of bits 6..4
    a_pullup_override_enable[6:4] = {3{spi_master}};
    a_pullup_override_value[6:4] = port_a_output_data[6:4] & {3{global_pullup_disable}};
    a_direction_override_enable[6] = spi_master;
    a_direction_override_enable[5] = spi_master | two_wire_here;
    a_direction_override_enable[4] = spi_master | two_wire_here;
    a_direction_override_value[5] = (serial_clock_hold | port_a_output_data[5]) & port_a_direction[5];
    a_direction_override_value[4] = spi_master ? 1'b0 :
                ((serial_shift_out | port_a_output_data[4]) & port_a_direction[4]);
    a_output_value_override_enable[5] = spi_master | (two_wire_here & port_a_direction[5]);
    a_output_value_override_enable[4] = spi_master | (two_wire_here & port_a_direction[4]);
    a_output_value_override_value[5] = spi_master ? spi_clock_out : ~(two_wire_here & port_a_direction[5]);
    a_output_value_override_value[4] = spi_master ? spi_data_out : ~(two_wire_here & port_a_direction[4]);
    a_input_enable_override_enable[5] = a_input_enable_override_enable[5] | (serial_start_irq_enable & serial_pin_position_select);
    a_input_enable_override_enable[4] = a_input_enable_override_enable[4] | (serial_start_irq_enable & serial_pin_position_select);
    a_input_enable_override_value[5] = a_input_enable_override_value[5] | (serial_start_irq_enable & serial_pin_position_select);
    a_input_enable_override_value[4] = a_input_enable_override_value[4] | (serial_start_irq_enable & serial_pin_position_select);
  end

  // ----------------------------------------
  // Port B overrides
  // ----------------------------------------
  reg [7:0] b_output_value_override_enable, b_output_value_override_value, b_input_enable_override_enable, b_input_enable_override_value;
  reg [7:0] steer_en;
  always @* begin
    // Steering bit k routes the A output to even pins, B to odd pins
    steer_en = timer1_output_steering_reg;
    b_output_value_override_enable = 8'h00;
    b_output_value_override_value = 8'h00;
    b_output_value_override_enable[0] = timer1_out_a_enabled & steer_en[0] & port_b_direction[0];
    b_output_value_override_value[0] = timer1_out_a;
    b_output_value_override_enable[1] = (timer1_out_b_enabled & steer_en[1] & port_b_direction[1]) |
                (serial_three_wire_active & port_b_direction[1]);
    b_output_value_override_value[1] = (timer1_out_b_enabled & steer_en[1]) ? timer1_out_b : serial_shift_out;
    b_output_value_override_enable[2] = timer1_out_a_enabled & steer_en[2] & port_b_direction[2];
    b_output_value_override_value[2] = timer1_out_a;
    b_output_value_override_enable[3] = timer1_out_b_enabled & steer_en[3];
    b_output_value_override_value[3] = timer1_out_b;
    b_output_value_override_enable[4] = timer1_out_a_enabled & steer_en[4];
    b_output_value_override_value[4] = timer1_out_a;
    b_output_value_override_enable[5] = timer1_out_b_enabled & steer_en[5];
    b_output_value_override_value[5] = timer1_out_b;
    b_output_value_override_enable[6] = timer1_out_a_enabled & steer_en[6];
    b_output_value_override_value[6] = timer1_out_a;
    b_output_value_override_enable[7] = timer1_out_b_enabled & steer_en[7];
    b_output_value_override_value[7] = timer1_out_b;
    // Bit 0 serial input deliberately absent: it overrides nothing
    b_input_enable_override_enable = analog_digital_disable_b | ({8{pin_change_group1_enable}} & pin_change_mask_b);
    b_input_enable_override_value = {8{pin_change_group1_enable}} & pin_change_mask_b;
    b_input_enable_override_enable[6] = b_input_enable_override_enable[6] | external_irq0_enabled;
    b_input_enable_override_value[6] = b_input_enable_override_value[6] | external_irq0_enabled;
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  wire [7:0] a_out, a_oe, a_pu, a_ie, b_out, b_oe, b_pu, b_ie;
  pin_driver #(.WIDTH(8)) u_drv_a (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .bbm_enable(port_control[`CTRL_BBM_A]),
    .pullup_disable(global_pullup_disable),
    .output_data(port_a_output_data),
    .direction(port_a_direction),
    .pullup_override_enable(a_pullup_override_enable),
    .pullup_override_value(a_pullup_override_value),
    .direction_override_enable(a_direction_override_enable),
    .direction_override_value(a_direction_override_value),
    .output_value_override_enable(a_output_value_override_enable),
    .output_value_override_value(a_output_value_override_value),
    .input_enable_override_enable(a_input_enable_override_enable),
    .input_enable_override_value(a_input_enable_override_value),
    .pin_out(a_out),
    .pin_oe(a_oe),
    .pin_pullup(a_pu),
    .pin_input_enable(a_ie)
  );
  // Bit 1 pull-up left on the normal path under three-wire mode
  pin_driver #(.WIDTH(8)) u_drv_b (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .bbm_enable(port_control[`CTRL_BBM_B]),
    .pullup_disable(global_pullup_disable),
    .output_data(port_b_output_data),
    .direction(port_b_direction),
    .pullup_override_enable(8'h00),
    .pullup_override_value(8'h00),
    .direction_override_enable(8'h00),
    .direction_override_value(8'h00),
    .output_value_override_enable(b_output_value_override_enable),
    .output_value_override_value(b_output_value_override_value),
    .input_enable_override_enable(b_input_enable_override_enable),
    .input_enable_override_value(b_input_enable_override_value),
    .pin_out(b_out),
    .pin_oe(b_oe),
    .pin_pullup(b_pu),
    .pin_input_enable(b_ie)
  );

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_pad_out <= 8'h00;
      port_a_pad_oe <= 8'h00;
      port_a_pullup <= 8'h00;
      port_a_input_enable <= 8'h00;
      port_b_pad_out <= 8'h00;
      port_b_pad_oe <= 8'h00;
      port_b_pullup <= 8'h00;
      port_b_input_enable <= 8'h00;
    end else if (clk_en) begin
      port_a_pad_out <= a_out;
      port_a_pad_oe <= a_oe;
      port_a_pullup <= a_pu;
      port_a_input_enable <= a_ie;
      port_b_pad_out <= b_out;
      port_b_pad_oe <= b_oe;
      port_b_pullup <= b_pu;
      port_b_input_enable <= b_ie;
    end
  end
endmodule

// >>> sim/pin_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port-side rule checker
// ----------------------------------------
module pin_chk (
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  input wire [3:0] reg_addr,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire [7:0] port_a_pad_out,
  input wire [7:0] port_a_pad_oe,
  input wire [7:0] port_a_pullup,
  input wire [7:0] port_a_input_enable,
  input wire [7:0] port_b_pad_oe,
  input wire [7:0] port_b_pullup,
  input wire [7:0] port_b_input_enable,
  input wire spi_enable_bit,
  input wire spi_master_select,
  input wire spi_clock_out,
  input wire serial_pin_position_select,
  input wire serial_start_irq_enable,
  input wire pin_change_group0_enable,
  input wire pin_change_group1_enable,
  input wire [7:0] pin_change_mask_a,
  input wire [7:0] pin_change_mask_b,
  input wire [7:0] analog_digital_disable_a,
  input wire external_irq0_enabled
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire master = spi_enable_bit & spi_master_select;
  wire a5_wake = (serial_start_irq_enable & serial_pin_position_select) | (pin_change_group0_enable & pin_change_mask_a[5]);
  // Reset is the antecedent here, so it must not disable the check
  AST_RST_PULLUP: assert property (disable iff (1'b0) !resetn |-> (port_a_pullup | port_b_pullup) == 8'h00)
    else $error("pull-up active in reset");
  AST_RDATA_IDLE: assert property (clk_en && !reg_read |=> reg_rdata == 8'h00)
    else $error("read data without read");
  AST_UNMAPPED: assert property (clk_en && reg_read && reg_addr > 4'h6 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_B_PULL_OE: assert property ((port_b_pullup & port_b_pad_oe) == 8'h00)
    else $error("pull-up on driven pin");
  AST_SPI_CLK: assert property ((master && $stable(spi_clock_out))[*3] |-> port_a_pad_out[5] == spi_clock_out)
    else $error("spi clock not on pin");
  AST_MOSI_DIR: assert property (master[*3] |-> !port_a_pad_oe[4])
    else $error("pin a4 driven as master");
  AST_A5_IEN_OFF: assert property ((analog_digital_disable_a[5] && !a5_wake)[*3] |-> !port_a_input_enable[5])
    else $error("a5 input not disabled");
  AST_A5_IEN_ON: assert property ((pin_change_group0_enable && pin_change_mask_a[5])[*3] |-> port_a_input_enable[5])
    else $error("a5 input not enabled");
  AST_B6_IEN_ON: assert property ((external_irq0_enabled || pin_change_group1_enable && pin_change_mask_b[6])[*3]
    |-> port_b_input_enable[6])
    else $error("b6 input not enabled");
endmodule

// >>> sim/pad_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Pad wires and board drivers
// ----------------------------------------
module pad_model (
  input wire ref_clk,
  input wire [7:0] pad_out,
  input wire [7:0] pad_oe,
  input wire [7:0] pull_en,
  input wire [7:0] ext_en,
  input wire [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic [7:0] wander = 8'h55;
  // Floating pins wander so a stale level never passes for a drive
  always @(posedge ref_clk) wander <= ~wander;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pull_en[i] ? 1'b1 : wander[i];
    end
  end
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ns
`include "port_override_defs.vh"
module tb_top;
  logic ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata, port_a_pad_in, port_b_pad_in, port_a_pad_out, port_a_pad_oe, port_a_pullup;
  wire [7:0] port_a_input_enable, port_b_pad_out, port_b_pad_oe, port_b_pullup, port_b_input_enable;
  logic spi_enable_bit = 1'b0, spi_master_select = 1'b0, spi_clock_out = 1'b0, spi_data_out = 1'b0;
  logic serial_two_wire_active = 1'b0, serial_three_wire_active = 1'b0, serial_pin_position_select = 1'b0;
  logic serial_clock_hold = 1'b0, serial_shift_out = 1'b0, serial_start_irq_enable = 1'b0;
  logic pin_change_group0_enable = 1'b0, pin_change_group1_enable = 1'b0, external_irq0_enabled = 1'b0;
  logic [7:0] pin_change_mask_a = 8'h00, pin_change_mask_b = 8'h00;
  logic [7:0] analog_digital_disable_a = 8'h00, analog_digital_disable_b = 8'h00;
  logic timer1_out_a = 1'b0, timer1_out_b = 1'b0, timer1_out_a_enabled = 1'b0, timer1_out_b_enabled = 1'b0;
  logic [7:0] timer1_output_steering_reg = 8'h00, a_ext_en = 8'h00, a_ext_val = 8'h00;
  logic [7:0] b_ext_en = 8'h00, b_ext_val = 8'h00;
  int fail_count = 0, check_count = 0, cycles = 0;
  port_pin_override_logic u_port_pin_override_logic (.*);
  pad_model u_pad_model_a (.ref_clk(ref_clk), .pad_out(port_a_pad_out), .pad_oe(port_a_pad_oe),
    .pull_en(port_a_pullup), .ext_en(a_ext_en), .ext_val(a_ext_val), .pad_in(port_a_pad_in));
  pad_model u_pad_model_b (.ref_clk(ref_clk), .pad_out(port_b_pad_out), .pad_oe(port_b_pad_oe),
    .pull_en(port_b_pullup), .ext_en(b_ext_en), .ext_val(b_ext_val), .pad_in(port_b_pad_in));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Bus access and checking
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    // Whole run is under 600 cycles
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [3:0] a;
    for (int k = 1; k < 6; k++) begin
      a = 4'(k);
      if (k != 3) begin
        rd(a, 8'h00);
        wr(a, {4'h5, a});
        rd(a, {4'h5, a});
        wr(a, 8'h00);
      end
    end
    wr(`ADDR_PORT_CONTROL, 8'hff);
    rd(`ADDR_PORT_CONTROL, 8'h07);
    wr(`ADDR_PORT_CONTROL, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_toggle;
    wr(`ADDR_PORT_A_OUTPUT_DATA, 8'h0f);
    wr(`ADDR_PORT_A_DIRECTION, 8'hf0);
    wr(`ADDR_PORT_A_PIN_INPUT, 8'h3c);
    rd(`ADDR_PORT_A_OUTPUT_DATA, 8'h33);
    wr(`ADDR_PORT_A_PIN_INPUT, 8'h00);
    rd(`ADDR_PORT_A_OUTPUT_DATA, 8'h33);
    wr(`ADDR_PORT_A_OUTPUT_DATA, 8'h00);
    wr(`ADDR_PORT_A_DIRECTION, 8'h00);
    a_ext_en <= 8'hff;
    a_ext_val <= 8'hc3;
    b_ext_en <= 8'hff;
    b_ext_val <= 8'h97;
    wt(6);
    rd(`ADDR_PORT_A_PIN_INPUT, 8'hc3);
    rd(`ADDR_PORT_B_PIN_INPUT, 8'h97);
    $display("t_toggle done");
  endtask
  task automatic t_pullup;
    wr(`ADDR_PORT_A_OUTPUT_DATA, 8'hff);
    wt(3);
    chk(port_a_pullup, 8'hff);
    wr(`ADDR_PORT_CONTROL, 8'h01);
    wt(3);
    chk(port_a_pullup, 8'h00);
    wr(`ADDR_PORT_CONTROL, 8'h00);
    wt(3);
    resetn <= 1'b0;
    #2;
    chk(port_a_pullup, 8'h00);
    wt(2);
    resetn <= 1'b1;
    rd(`ADDR_PORT_A_OUTPUT_DATA, 8'h00);
    $display("t_pullup done");
  endtask
  task automatic lat(output int n);
    wr(`ADDR_PORT_A_DIRECTION, 8'h00);
    wt(3);
    wr(`ADDR_PORT_A_DIRECTION, 8'h01);
    n = 0;
    while (port_a_pad_oe[0] !== 1'b1 && n < 8) begin
      wt(1);
      n++;
    end
  endtask
  task automatic t_bbm;
    int n0, n1;
    lat(n0);
    wr(`ADDR_PORT_CONTROL, 8'h02);
    lat(n1);
    chk(8'(n1 - n0), 8'h01);
    wr(`ADDR_PORT_CONTROL, 8'h00);
    wr(`ADDR_PORT_A_DIRECTION, 8'h00);
    $display("t_bbm done");
  endtask
  task automatic t_three;
    serial_three_wire_active <= 1'b1;
    serial_shift_out <= 1'b1;
    wr(`ADDR_PORT_B_OUTPUT_DATA, 8'h02);
    wr(`ADDR_PORT_B_DIRECTION, 8'h02);
    wt(3);
    chk({6'h0, port_b_pad_oe[1], port_b_pad_out[1]}, 8'h03);
    serial_shift_out <= 1'b0;
    wt(3);
    chk({6'h0, port_b_pad_out[1], port_b_pad_oe[0]}, 8'h00);
    wr(`ADDR_PORT_B_DIRECTION, 8'h00);
    wt(3);
    chk({7'h0, port_b_pullup[1]}, 8'h01);
    serial_three_wire_active <= 1'b0;
    wr(`ADDR_PORT_B_OUTPUT_DATA, 8'h00);
    $display("t_three done");
  endtask
  task automatic t_timer;
    timer1_output_steering_reg <= 8'h03;
    timer1_out_a_enabled <= 1'b1;
    timer1_out_b_enabled <= 1'b1;
    timer1_out_a <= 1'b1;
    wt(3);
    chk(port_b_pad_oe, 8'h00);
    wr(`ADDR_PORT_B_DIRECTION, 8'h03);
    wt(3);
    chk({6'h0, port_b_pad_out[1:0]}, 8'h01);
    timer1_out_a <= 1'b0;
    timer1_out_b <= 1'b1;
    wt(3);
    chk({6'h0, port_b_pad_out[1:0]}, 8'h02);
    timer1_output_steering_reg <= 8'h00;
    wr(`ADDR_PORT_B_DIRECTION, 8'h00);
    $display("t_timer done");
  endtask
  task automatic t_spi;
    wr(`ADDR_PORT_A_DIRECTION, 8'h10);
    spi_enable_bit <= 1'b1;
    spi_master_select <= 1'b1;
    spi_clock_out <= 1'b1;
    wt(4);
    chk({6'h0, port_a_pad_out[5], port_a_pad_oe[4]}, 8'h02);
    spi_clock_out <= 1'b0;
    wt(4);
    chk({7'h0, port_a_pad_out[5]}, 8'h00);
    spi_enable_bit <= 1'b0;
    serial_two_wire_active <= 1'b1;
    serial_pin_position_select <= 1'b1;
    wr(`ADDR_PORT_A_OUTPUT_DATA, 8'h20);
    wr(`ADDR_PORT_A_DIRECTION, 8'h20);
    wt(3);
    chk({7'h0, port_a_pad_out[5]}, 8'h00);
    serial_two_wire_active <= 1'b0;
    wr(`ADDR_PORT_A_DIRECTION, 8'h00);
    $display("t_spi done");
  endtask
  task automatic t_inen;
    analog_digital_disable_a <= 8'h20;
    analog_digital_disable_b <= 8'h40;
    wt(4);
    chk({6'h0, port_b_input_enable[6], port_a_input_enable[5]}, 8'h00);
    pin_change_group0_enable <= 1'b1;
    pin_change_mask_a <= 8'h20;
    external_irq0_enabled <= 1'b1;
    wt(4);
    chk({6'h0, port_b_input_enable[6], port_a_input_enable[5]}, 8'h03);
    external_irq0_enabled <= 1'b0;
    pin_change_group1_enable <= 1'b1;
    pin_change_mask_b <= 8'h40;
    wt(4);
    chk({7'h0, port_b_input_enable[6]}, 8'h01);
    $display("t_inen done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs();
    t_toggle();
    t_pullup();
    t_bbm();
    t_three();
    t_timer();
    t_spi();
    t_inen();
    complete_run();
  end
endmodule
bind port_pin_override_logic pin_chk u_pin_chk (.*);
